/* core/rdc_pkg.sv */
// Constants and types for the redriver strap and detect control
`default_nettype none
package rdc_pkg;
    // Strap level codes from the four-level comparators
    localparam logic [1:0] LVL0 = 2'h0;
    localparam logic [1:0] LVL1 = 2'h1;
    localparam logic [1:0] LVL2 = 2'h2;
    localparam logic [1:0] LVL3 = 2'h3;
    // Detect poll interval, rounded down to whole cycles
    localparam int CLK_NS = 5;
    localparam int POLL_NS = 150000;
    localparam int POLL_CYC = POLL_NS / CLK_NS;
    // Slave address bases
    localparam logic [6:0] BASE_L1 = 7'h18;
    localparam logic [6:0] BASE_L2 = 7'h20;
    // Register offsets
    localparam logic [7:0] REG_EQ = 8'h00;
    localparam logic [7:0] REG_DET = 8'h01;
    localparam logic [7:0] REG_STAT = 8'h02;
    localparam logic [7:0] REG_STRAP = 8'h03;
    localparam logic [7:0] EQ_RST = 8'h00;
    typedef enum logic [1:0] {
        DET_IDLE, DET_PROBE, DET_SAMPLE, DET_WAIT
    } rdc_det_t;
    typedef enum logic [2:0] {
        I2C_IDLE, I2C_ADDR, I2C_PTR, I2C_WDATA, I2C_ACK, I2C_RDATA,
        I2C_MACK
    } rdc_i2c_t;
endpackage
`default_nettype wire

/* core/rdc_i2c_slave.sv */
// Two-wire slave that answers two adjacent addresses
`timescale 1ns/1ps
`default_nettype none
module rdc_i2c_slave (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic slave_en,
    input wire logic [6:0] dev_addr,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_oe,
    output logic wr_stb,
    output logic [7:0] wr_data,
    output logic [7:0] ptr,
    output logic bank,
    input wire logic [7:0] rd_data
);
    rdc_pkg::rdc_i2c_t st_q, st_d, nxt_q, nxt_d;
    logic [2:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d, ptr_q, ptr_d;
    logic full_q, full_d, oe_q, oe_d, bank_q, bank_d;
    logic scl_q, sda_q;
    logic rise, fall, start, stop, hit0, hit1;

    // Bus conditions seen against the previous sample
    assign rise = scl_i & ~scl_q;
    assign fall = ~scl_i & scl_q;
    assign start = scl_i & scl_q & sda_q & ~sda_i;
    assign stop = scl_i & scl_q & ~sda_q & sda_i;
    assign hit0 = sh_q[7:1] == dev_addr;
    assign hit1 = sh_q[7:1] == 7'(dev_addr + 7'h01);

    // Bit engine: shift on rise, drive on fall
    always_comb
    begin
        st_d = st_q;
        nxt_d = nxt_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        ptr_d = ptr_q;
        full_d = full_q;
        oe_d = oe_q;
        bank_d = bank_q;
        wr_stb = 1'b0;
        if (!slave_en || stop)
        begin
            st_d = rdc_pkg::I2C_IDLE;
            oe_d = 1'b0;
        end
        else if (start)
        begin
            st_d = rdc_pkg::I2C_ADDR;
            cnt_d = 3'h0;
            full_d = 1'b0;
            oe_d = 1'b0;
        end
        else if (rise && (st_q == rdc_pkg::I2C_ADDR ||
                 st_q == rdc_pkg::I2C_PTR || st_q == rdc_pkg::I2C_WDATA))
        begin
            sh_d = {sh_q[6:0], sda_i};
            cnt_d = 3'(cnt_q + 3'h1);
            full_d = cnt_q == 3'h7;
        end
        else if (fall && full_q && st_q != rdc_pkg::I2C_RDATA)
        begin
            full_d = 1'b0;
            oe_d = 1'b1;
            st_d = rdc_pkg::I2C_ACK;
            case (st_q)
                rdc_pkg::I2C_ADDR:
                begin
                    bank_d = hit1;
                    nxt_d = sh_q[0] ? rdc_pkg::I2C_RDATA : rdc_pkg::I2C_PTR;
                    if (!(hit0 || hit1))
                    begin
                        st_d = rdc_pkg::I2C_IDLE; // Not ours: stay off
                        oe_d = 1'b0;
                    end
                end
                rdc_pkg::I2C_PTR:
                begin
                    ptr_d = sh_q;
                    nxt_d = rdc_pkg::I2C_WDATA;
                end
                default:
                begin
                    wr_stb = 1'b1;
                    ptr_d = 8'(ptr_q + 8'h01);
                    nxt_d = rdc_pkg::I2C_WDATA;
                end
            endcase
        end
        else if (fall && st_q == rdc_pkg::I2C_ACK)
        begin
            st_d = nxt_q;
            cnt_d = 3'h0;
            sh_d = rd_data;
            oe_d = (nxt_q == rdc_pkg::I2C_RDATA) & ~rd_data[7];
        end
        else if (rise && st_q == rdc_pkg::I2C_RDATA)
        begin
            cnt_d = 3'(cnt_q + 3'h1);
            full_d = cnt_q == 3'h7;
        end
        else if (fall && st_q == rdc_pkg::I2C_RDATA)
        begin
            if (full_q)
            begin
                full_d = 1'b0;
                oe_d = 1'b0; // Release for the master's ack
                st_d = rdc_pkg::I2C_MACK;
            end
            else
            begin
                sh_d = {sh_q[6:0], 1'b0};
                oe_d = ~sh_q[6];
            end
        end
        else if (rise && st_q == rdc_pkg::I2C_MACK)
        begin
            if (sda_i)
                st_d = rdc_pkg::I2C_IDLE;
            else
                ptr_d = 8'(ptr_q + 8'h01);
        end
        else if (fall && st_q == rdc_pkg::I2C_MACK)
        begin
            st_d = rdc_pkg::I2C_RDATA;
            cnt_d = 3'h0;
            sh_d = rd_data;
            oe_d = ~rd_data[7];
        end
    end

    // Slave state registers
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_q <= rdc_pkg::I2C_IDLE;
            nxt_q <= rdc_pkg::I2C_IDLE;
            cnt_q <= 3'h0;
            sh_q <= 8'h00;
            ptr_q <= 8'h00;
            full_q <= 1'b0;
            oe_q <= 1'b0;
            bank_q <= 1'b0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
            nxt_q <= nxt_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            ptr_q <= ptr_d;
            full_q <= full_d;
            oe_q <= oe_d;
            bank_q <= bank_d;
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end

    assign sda_oe = oe_q;
    assign wr_data = sh_q;
    assign ptr = ptr_q;
    assign bank = bank_q;
endmodule // rdc_i2c_slave
`default_nettype wire

/* core/rdc_core.sv */
// Strap decode, receiver detect and register control of the redriver
`timescale 1ns/1ps
`default_nettype none
module rdc_core #(
    parameter int POLL_CYCLES = rdc_pkg::POLL_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [1:0] eq_index_high_strap_ch03,
    input wire logic [1:0] eq_index_low_strap_ch03,
    input wire logic [1:0] eq_index_high_strap_ch47,
    input wire logic [1:0] eq_index_low_strap_ch47,
    input wire logic [1:0] gain_strap,
    input wire logic [1:0] mode_strap,
    input wire logic [1:0] far_end_detect_strap,
    input wire logic [1:0] addr_strap,
    input wire logic power_down_pin,
    input wire logic sel_pin,
    input wire logic [3:0] far_end_present,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic [3:0] eq_index_ch03,
    output logic [3:0] eq_index_ch47,
    output logic [1:0] flat_gain,
    output logic [3:0] rx_term_50,
    output logic [3:0] detect_probe,
    output logic path_reset,
    output logic standby
);
    // Index from two level codes
    function automatic logic [3:0] eq_idx(input logic [1:0] hi,
                                          input logic [1:0] lo);
        eq_idx = {hi, lo};
    endfunction

    // Strap capture state
    logic cap_q, cap_d;
    logic [3:0] seq0_q, seq0_d, seq1_q, seq1_d;
    logic [1:0] gain_q, gain_d;
    logic detoff_q, detoff_d;
    // Register file and outputs
    logic [7:0] eqreg_q, eqreg_d, rdata_q, rdata_d;
    logic [3:0] eq0_q, eq0_d, eq1_q, eq1_d;
    // Detect machine
    rdc_pkg::rdc_det_t st_q, st_d;
    logic [3:0] pend_q, pend_d, found_q, found_d, term_q, term_d;
    logic [3:0] probe_q, probe_d, trig, hit_w;
    logic [15:0] tmr_q, tmr_d;
    logic pd_q, sel_q, stby_q, stby_d, all_ev;
    // Serial slave link
    logic slv_en, i_wr, i_bank;
    logic [7:0] i_wd, i_ptr, i_rd;
    logic [6:0] slv_base;
    logic wr_any;
    logic [7:0] wr_a, wr_d;

    // Read view shared by the plain port and the serial slave
    function automatic logic [7:0] reg_read(input logic [7:0] a,
        input logic [7:0] eqr, input logic [3:0] term,
        input logic [1:0] md, input logic sb, input logic busy,
        input logic [3:0] s0, input logic [3:0] s1);
        case (a)
            rdc_pkg::REG_EQ: reg_read = eqr;
            rdc_pkg::REG_STAT: reg_read = {busy, sb, md, term};
            rdc_pkg::REG_STRAP: reg_read = {s1, s0};
            default: reg_read = 8'h00; // Unmapped and trigger read zero
        endcase
    endfunction

    // Slave active in both addressed modes; base picked by mode
    assign slv_en = mode_strap == rdc_pkg::LVL1 ||
                    mode_strap == rdc_pkg::LVL2;
    assign slv_base = 7'((mode_strap == rdc_pkg::LVL2 ? rdc_pkg::BASE_L2 :
                      rdc_pkg::BASE_L1) + {4'h0, addr_strap, 1'b0});

    assign i_rd = reg_read(i_ptr, eqreg_q, term_q, mode_strap, stby_q,
                           st_q != rdc_pkg::DET_IDLE, seq0_q, seq1_q);

    rdc_i2c_slave u_slave (
        .clk(clk),
        .sys_rst(sys_rst),
        .slave_en(slv_en),
        .dev_addr(slv_base),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .sda_oe(sda_oe),
        .wr_stb(i_wr),
        .wr_data(i_wd),
        .ptr(i_ptr),
        .bank(i_bank),
        .rd_data(i_rd)
    );
    assign sda_o = 1'b0; // Open drain: only ever pulls low

    // Plain port wins a same-cycle collision with the serial slave
    assign wr_any = reg_wr | i_wr;
    assign wr_a = reg_wr ? reg_addr : i_ptr;
    assign wr_d = reg_wr ? reg_wdata : i_wd;

    // Per-channel detect requests; serial bank maps two channels
    always_comb
    begin
        trig = 4'h0;
        if (reg_wr && reg_addr == rdc_pkg::REG_DET)
            trig = reg_wdata[3:0];
        else if (i_wr && i_ptr == rdc_pkg::REG_DET)
            trig = i_bank ? {i_wd[1:0], 2'b00} : {2'b00, i_wd[1:0]};
    end

    // Straps taken once, in the first cycle after reset release
    always_comb
    begin
        cap_d = 1'b1;
        seq0_d = seq0_q;
        seq1_d = seq1_q;
        gain_d = gain_q;
        detoff_d = detoff_q;
        if (!cap_q)
        begin
            seq0_d = eq_idx(eq_index_high_strap_ch03,
                            eq_index_low_strap_ch03);
            seq1_d = eq_idx(eq_index_high_strap_ch47,
                            eq_index_low_strap_ch47);
            gain_d = gain_strap;
            detoff_d = far_end_detect_strap == rdc_pkg::LVL0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cap_q <= 1'b0;
            seq0_q <= 4'h0;
            seq1_q <= 4'h0;
            gain_q <= rdc_pkg::LVL3;
            detoff_q <= 1'b0;
        end
        else
        begin
            cap_q <= cap_d;
            seq0_q <= seq0_d;
            seq1_q <= seq1_d;
            gain_q <= gain_d;
            detoff_q <= detoff_d;
        end
    end

    // Register file, read data and equalization outputs
    always_comb
    begin
        eqreg_d = eqreg_q;
        if (wr_any && wr_a == rdc_pkg::REG_EQ)
            eqreg_d = wr_d;
        rdata_d = 8'h00;
        if (reg_rd)
            rdata_d = reg_read(reg_addr, eqreg_q, term_q, mode_strap,
                stby_q, st_q != rdc_pkg::DET_IDLE, seq0_q, seq1_q);
        // Mode is live, so a change takes effect on the next clock
        if (mode_strap == rdc_pkg::LVL0)
        begin
            eq0_d = seq0_q;
            eq1_d = seq1_q;
        end
        else
        begin
            eq0_d = eqreg_q[3:0];
            eq1_d = eqreg_q[7:4];
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            eqreg_q <= rdc_pkg::EQ_RST;
            rdata_q <= 8'h00;
            eq0_q <= 4'h0;
            eq1_q <= 4'h0;
        end
        else
        begin
            eqreg_q <= eqreg_d;
            rdata_q <= rdata_d;
            eq0_q <= eq0_d;
            eq1_q <= eq1_d;
        end
    end

    // Power-up, power-down release and select edge probe all channels
    assign all_ev = !cap_q || (pd_q && !power_down_pin) ||
                    (sel_q != sel_pin);
    assign hit_w = far_end_present & pend_q;

    // Detect machine: probe, sample, then wait and retry
    always_comb
    begin
        st_d = st_q;
        tmr_d = tmr_q;
        pend_d = pend_q | trig | (all_ev ? 4'hF : 4'h0);
        found_d = found_q & ~trig;
        stby_d = power_down_pin;
        case (st_q)
            rdc_pkg::DET_IDLE:
                if (pend_q != 4'h0 && !detoff_q && cap_q)
                    st_d = rdc_pkg::DET_PROBE;
            rdc_pkg::DET_PROBE:
                st_d = rdc_pkg::DET_SAMPLE;
            rdc_pkg::DET_SAMPLE:
            begin
                // A found far end wins over a same-cycle retrigger
                found_d = found_d | hit_w;
                pend_d = (pend_q & ~hit_w) | trig |
                         (all_ev ? 4'hF : 4'h0);
                tmr_d = 16'(POLL_CYCLES - 1);
                st_d = (pend_d != 4'h0) ? rdc_pkg::DET_WAIT :
                       rdc_pkg::DET_IDLE;
            end
            rdc_pkg::DET_WAIT:
                if (tmr_q == 16'h0000)
                    st_d = rdc_pkg::DET_PROBE;
                else
                    tmr_d = 16'(tmr_q - 16'h0001);
            default:
                st_d = rdc_pkg::DET_IDLE;
        endcase
        // Power-down drops results; release starts a fresh cycle
        if (power_down_pin)
        begin
            st_d = rdc_pkg::DET_IDLE;
            pend_d = 4'h0;
            found_d = 4'h0;
        end
        if (power_down_pin)
            term_d = 4'h0;
        else if (detoff_d)
            term_d = 4'hF;
        else
            term_d = found_d;
        probe_d = (st_d == rdc_pkg::DET_PROBE) ? pend_d : 4'h0;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_q <= rdc_pkg::DET_IDLE;
            tmr_q <= 16'h0000;
            pend_q <= 4'h0;
            found_q <= 4'h0;
            term_q <= 4'h0;
            probe_q <= 4'h0;
            stby_q <= 1'b0;
            pd_q <= 1'b0;
            sel_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            tmr_q <= tmr_d;
            pend_q <= pend_d;
            found_q <= found_d;
            term_q <= term_d;
            probe_q <= probe_d;
            stby_q <= stby_d;
            pd_q <= power_down_pin;
            sel_q <= sel_pin;
        end
    end

    assign reg_rdata = rdata_q;
    assign eq_index_ch03 = eq0_q;
    assign eq_index_ch47 = eq1_q;
    assign flat_gain = gain_q;
    assign rx_term_50 = term_q;
    assign detect_probe = probe_q;
    assign standby = stby_q;
    assign path_reset = stby_q;

    // Checks on the block's own behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_sample_live;
        st_q == rdc_pkg::DET_SAMPLE && !power_down_pin && !detoff_q;
    endsequence
    sequence s_wait_done;
        st_q == rdc_pkg::DET_WAIT && tmr_q == 16'h0000 && !power_down_pin;
    endsequence

    AST_PD_HIZ: assert property (
        power_down_pin |=> rx_term_50 == 4'h0 && path_reset)
        else $error("termination not high impedance in power-down");
    AST_STBY: assert property (
        power_down_pin ##1 !power_down_pin |=> !standby)
        else $error("standby not left after power-down release");
    AST_DET_OFF: assert property (
        (!power_down_pin && detoff_q && cap_q) |=> rx_term_50 == 4'hF)
        else $error("termination not 50 ohm with detect disabled");
    AST_EQ_PIN: assert property (
        (mode_strap == rdc_pkg::LVL0 && cap_q)
        |=> eq_index_ch03 == $past(seq0_q) && eq_index_ch47 == $past(seq1_q))
        else $error("pin mode does not use strap equalization");
    AST_EQ_REG: assert property (
        mode_strap != rdc_pkg::LVL0 |=> eq_index_ch03 == $past(eqreg_q[3:0]))
        else $error("serial mode does not use register equalization");
    AST_PDFALL: assert property (
        (cap_q && $fell(power_down_pin)) |=> pend_q == 4'hF)
        else $error("power-down release did not request all channels");
    AST_WAIT_PROBE: assert property (
        s_wait_done |=> st_q == rdc_pkg::DET_PROBE ##1
        st_q == rdc_pkg::DET_SAMPLE || power_down_pin)
        else $error("poll wait did not lead to a new probe");
    AST_FOUND: assert property (
        s_sample_live |=> (rx_term_50 & $past(hit_w)) == $past(hit_w))
        else $error("found far end not switched to 50 ohm");
    AST_STRAP_HOLD: assert property (
        cap_q |=> $stable(seq0_q) && $stable(gain_q))
        else $error("latched straps changed after power-up");

    // Event, probe, serial enable and gain capture guards
    AST_PD_CLR: assert property (
        power_down_pin |=> pend_q == 4'h0 && st_q == rdc_pkg::DET_IDLE)
        else $error("power-down did not clear pending detection");
    AST_PROBE_ONE: assert property (
        detect_probe != 4'h0 |=> detect_probe == 4'h0)
        else $error("detect probe lasted more than one cycle");
    AST_TRIG_CH: assert property (
        (reg_wr && reg_addr == rdc_pkg::REG_DET && !power_down_pin)
        |=> (pend_q & $past(reg_wdata[3:0])) == $past(reg_wdata[3:0]))
        else $error("register trigger did not request its channels");
    AST_SLV_OFF: assert property (
        !slv_en |=> !sda_oe)
        else $error("serial slave drove data outside its modes");
    AST_GAIN_CAP: assert property (
        (!cap_q && !sys_rst) |=> flat_gain == $past(gain_strap))
        else $error("gain strap not latched at power-up");
endmodule // rdc_core
`default_nettype wire

/* verification/rdc_far_end.sv */
// Far-end receiver termination model answering detect probes
`timescale 1ns/1ps
`default_nettype none
module rdc_far_end (
    input wire logic clk,
    input wire logic [3:0] present_mask,
    input wire logic [3:0] detect_probe,
    output logic [3:0] far_end_present
);
    logic [3:0] probe_q = 4'h0;
    logic [3:0] junk_q = 4'h5;
    // Probe is remembered one cycle; junk toggles so late samples fail
    always_ff @(posedge clk)
    begin
        probe_q <= detect_probe;
        junk_q <= ~junk_q;
    end
    // Termination is seen only in the cycle after a probe
    assign far_end_present = (probe_q != 4'h0) ? present_mask : junk_q;
endmodule // rdc_far_end
`default_nettype wire

/* verification/redriver_strap_and_rxdetect_control_test.sv */
// Self-checking bench for the strap and detect control block
`timescale 1ns/1ps
`default_nettype none
module redriver_strap_and_rxdetect_control_test;
    localparam int POLL = 20;
    localparam int Q = 125; // Quarter bit, keeps the bus at 400 kHz
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [1:0] eqh03 = 2'h2, eql03 = 2'h1, eqh47 = 2'h3, eql47 = 2'h0;
    logic [1:0] gain = 2'h1, mode = 2'h0, det = 2'h3, addr = 2'h0;
    logic pd = 1'b0, sel = 1'b0, scl_m = 1'b1, sda_m = 1'b1;
    logic [3:0] mask = 4'h5;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic sda_o, sda_oe, path_reset, standby, sda_i, ack;
    logic [7:0] reg_rdata, rdv;
    logic [3:0] eq03, eq47, rx_term_50, detect_probe, far_end_present;
    logic [1:0] flat_gain;
    int fail_count = 0;
    int compares = 0;
    logic [1:0] pm [4] = '{2'h2, 2'h2, 2'h2, 2'h1};
    logic [1:0] pa [4] = '{2'h1, 2'h1, 2'h1, 2'h3};
    logic [6:0] ps [4] = '{7'h22, 7'h23, 7'h20, 7'h1F};
    logic pk [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
    // Open-drain data line with pull-up
    assign sda_i = sda_m & ~sda_oe;

    rdc_core #(.POLL_CYCLES(POLL)) u_rdc_core (
        .clk(clk), .sys_rst(sys_rst),
        .eq_index_high_strap_ch03(eqh03), .eq_index_low_strap_ch03(eql03),
        .eq_index_high_strap_ch47(eqh47), .eq_index_low_strap_ch47(eql47),
        .gain_strap(gain), .mode_strap(mode), .far_end_detect_strap(det),
        .addr_strap(addr), .power_down_pin(pd), .sel_pin(sel),
        .far_end_present(far_end_present), .scl_i(scl_m), .sda_i(sda_i),
        .sda_o(sda_o), .sda_oe(sda_oe), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .eq_index_ch03(eq03), .eq_index_ch47(eq47),
        .flat_gain(flat_gain), .rx_term_50(rx_term_50),
        .detect_probe(detect_probe), .path_reset(path_reset),
        .standby(standby)
    );
    rdc_far_end u_rdc_far_end (
        .clk(clk), .present_mask(mask), .detect_probe(detect_probe),
        .far_end_present(far_end_present)
    );
    // 200 MHz clock
    initial
    begin
        forever #2.5 clk = ~clk;
    end

    task automatic summarize();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic wait_term(input logic [3:0] e, input int lim);
        int i;
        for (i = 0; i < lim && rx_term_50 !== e; i++)
        begin
            @(posedge clk);
            #1;
        end
        chk("rx_term_50", {4'h0, rx_term_50}, {4'h0, e});
    endtask
    // Probe lasts one cycle, so look just after every edge
    task automatic wait_probe(input logic [3:0] e, input int lim);
        int i;
        for (i = 0; i < lim && detect_probe == 4'h0; i++)
        begin
            @(posedge clk);
            #1;
        end
        chk("detect_probe", {4'h0, detect_probe}, {4'h0, e});
    endtask
    task automatic i2c_bit(input logic b, output logic r);
        cyc(Q);
        sda_m <= b;
        cyc(Q);
        scl_m <= 1'b1;
        cyc(Q);
        r = sda_i;
        cyc(Q);
        scl_m <= 1'b0;
    endtask
    task automatic i2c_start();
        cyc(Q);
        sda_m <= 1'b0;
        cyc(Q);
        scl_m <= 1'b0;
    endtask
    task automatic i2c_stop();
        cyc(Q);
        sda_m <= 1'b0;
        cyc(Q);
        scl_m <= 1'b1;
        cyc(Q);
        sda_m <= 1'b1;
        cyc(Q);
    endtask
    task automatic i2c_byte(input logic [7:0] d, output logic a);
        logic r;
        int i;
        for (i = 7; i >= 0; i--)
            i2c_bit(d[i], r);
        i2c_bit(1'b1, r);
        a = ~r;
    endtask
    // Master reads a byte MSB first, then acks or nacks it
    task automatic i2c_get(input logic nack, output logic [7:0] d);
        logic r;
        int i;
        for (i = 7; i >= 0; i--)
        begin
            i2c_bit(1'b1, r);
            d[i] = r;
        end
        i2c_bit(nack, r);
    endtask

    // Watchdog sized above the longest expected run
    initial
    begin
        repeat (95000) @(posedge clk);
        fail_count++;
        summarize();
    end

    initial
    begin
        cyc(3);
        #1;
        chk("flat_gain", {6'h0, flat_gain}, 8'h03);
        chk("rx_term_50", {4'h0, rx_term_50}, 8'h00);
        cyc(3);
        sys_rst <= 1'b0;
        cyc(3);
        eqh03 <= 2'h0;
        eql03 <= 2'h0;
        eqh47 <= 2'h0;
        gain <= 2'h0;
        cyc(4);
        #1;
        chk("eq_ch03", {4'h0, eq03}, 8'h09);
        chk("eq_ch47", {4'h0, eq47}, 8'h0C);
        chk("flat_gain", {6'h0, flat_gain}, 8'h01);
        wait_term(4'h5, 40);
        @(posedge clk);
        mask <= 4'hF;
        wait_term(4'hF, POLL + 40);
        rd(rdc_pkg::REG_STAT, rdv);
        chk("status", rdv, 8'h0F);
        @(posedge clk);
        mask <= 4'h0;
        wr(rdc_pkg::REG_DET, 8'h04);
        wait_probe(4'h4, 10);
        wait_term(4'hB, 10);
        rd(rdc_pkg::REG_DET, rdv);
        chk("det_read", rdv, 8'h00);
        rd(8'hFF, rdv);
        chk("unmapped", rdv, 8'h00);
        @(posedge clk);
        mask <= 4'hF;
        sel <= ~sel;
        // The channel 2 poll wait may still be running
        wait_probe(4'hF, POLL + 10);
        wait_term(4'hF, POLL + 40);
        @(posedge clk);
        pd <= 1'b1;
        cyc(3);
        #1;
        chk("rx_term_50", {4'h0, rx_term_50}, 8'h00);
        chk("standby", {7'h0, standby}, 8'h01);
        chk("path_reset", {7'h0, path_reset}, 8'h01);
        cyc(40000);
        pd <= 1'b0;
        wait_probe(4'hF, 10);
        wait_term(4'hF, 10);
        chk("standby", {7'h0, standby}, 8'h00);
        @(posedge clk);
        mode <= 2'h1;
        wr(rdc_pkg::REG_EQ, 8'h5A);
        cyc(3);
        #1;
        chk("eq_ch03", {4'h0, eq03}, 8'h0A);
        chk("eq_ch47", {4'h0, eq47}, 8'h05);
        rd(rdc_pkg::REG_EQ, rdv);
        chk("eq_reg", rdv, 8'h5A);
        @(posedge clk);
        mode <= 2'h0;
        cyc(3);
        #1;
        chk("eq_ch03", {4'h0, eq03}, 8'h09);
        // Address table over both modes, banks and a foreign address
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clk);
            mode <= pm[k];
            addr <= pa[k];
            i2c_start();
            i2c_byte({ps[k], 1'b0}, ack);
            i2c_stop();
            chk("slave_ack", {7'h0, ack}, {7'h0, pk[k]});
        end
        @(posedge clk);
        mode <= 2'h2;
        addr <= 2'h1;
        i2c_start();
        i2c_byte(8'h44, ack);
        chk("addr_ack", {7'h0, ack}, 8'h01);
        i2c_byte(rdc_pkg::REG_EQ, ack);
        chk("ptr_ack", {7'h0, ack}, 8'h01);
        i2c_byte(8'h3C, ack);
        chk("data_ack", {7'h0, ack}, 8'h01);
        i2c_stop();
        cyc(3);
        #1;
        chk("eq_ch03", {4'h0, eq03}, 8'h0C);
        chk("eq_ch47", {4'h0, eq47}, 8'h03);
        // Serial read from the advanced pointer, then the status byte
        i2c_start();
        i2c_byte(8'h45, ack);
        chk("rd_ack", {7'h0, ack}, 8'h01);
        i2c_get(1'b0, rdv);
        chk("i2c_det", rdv, 8'h00);
        i2c_get(1'b1, rdv);
        i2c_stop();
        chk("i2c_stat", rdv, 8'h2F);
        chk("sda_o", {7'h0, sda_o}, 8'h00);
        // Second power-up with detect disabled relatches straps
        @(posedge clk);
        sys_rst <= 1'b1;
        det <= 2'h0;
        eqh03 <= 2'h1;
        mask <= 4'h0;
        mode <= 2'h0;
        cyc(6);
        sys_rst <= 1'b0;
        cyc(6);
        #1;
        chk("rx_term_50", {4'h0, rx_term_50}, 8'h0F);
        chk("eq_ch03", {4'h0, eq03}, 8'h04);
        chk("flat_gain", {6'h0, flat_gain}, 8'h00);
        // Mode L3 leaves the straps and takes the register index
        @(posedge clk);
        mode <= 2'h3;
        cyc(3);
        #1;
        chk("eq_ch03", {4'h0, eq03}, 8'h00);
        summarize();
    end
endmodule // redriver_strap_and_rxdetect_control_test
`default_nettype wire
